// *** pkg/lcd_drive_pkg.sv ***
// Constants, states and carriers shared by the LCD drive block
package lcd_drive_pkg;

  // Host pin group as it arrives from the board
  typedef struct packed {
    logic       cs_n;    // Chip select, active low
    logic       cmd_sel; // Command/data select
    logic       rd_e;    // Read strobe or enable clock
    logic       wr_rw;   // Write strobe or read/write line
    logic [7:0] data;    // Host data bus
  } host_pins_s;

  // Reset value of the host pins: deselected, strobes at their idle levels for bus style 0
  localparam host_pins_s HOST_PINS_IDLE = '{cs_n: 1'b1, cmd_sel: 1'b0, rd_e: 1'b1,
                                            wr_rw: 1'b1, data: 8'h00};

  // Display line sequencer, Gray along fetch, shift, latch, write
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_FETCH = 3'b001,
    ST_SHIFT = 3'b011,
    ST_LATCH = 3'b010,
    ST_WRITE = 3'b110
  } line_state_e;

  // Phases of one four-cycle slot
  localparam logic [1:0] PH_SET  = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // Reset values of the panel and memory pins
  localparam logic       LATCH_RST   = 1'b0;
  localparam logic       DRIVE_RST   = 1'b0;
  localparam logic       STANDBY_RST = 1'b1;
  localparam logic       STROBE_RST  = 1'b1;
  localparam logic [7:0] AC_LINES    = 8'h10;  // Lines per AC half period, short mode

endpackage

// *** verilog/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys_in,  // System clock
  input  wire logic         rst_in,      // Asynchronous reset
  input  wire logic [W-1:0] pin_in,      // Raw pins
  output logic      [W-1:0] sync_out     // Filtered pins
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Only stage2 reads meta; a bit moves once stage2 and stage3 agree
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta     <= RST_VAL;
      stage2   <= RST_VAL;
      stage3   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta   <= pin_in;
      stage2 <= meta;
      stage3 <= stage2;
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule // pin_sync

// *** verilog/lcd_panel_drive.sv ***
// LCD controller pin logic: host port, display memory port, panel drive
module lcd_panel_drive #(
  parameter int BYTE_W = 8,   // Width of the bytes-per-line setting
  parameter int LINE_W = 8    // Width of the lines-per-frame setting
) (
  input  wire logic              clk_sys_in,          // System clock
  input  wire logic              rst_in,              // Asynchronous reset
  input  wire logic              hardware_reset_in,   // Reset pin
  input  wire logic              bus_style_select_in, // Host bus style pin
  input  wire logic              cmd_data_select_in,  // Host command/data pin
  input  wire logic              cs_n_in,             // Host chip select pin
  input  wire logic              rd_e_in,             // Read strobe or enable
  input  wire logic              wr_rw_in,            // Write strobe or R/W
  input  wire logic [7:0]        host_data_in,        // Host data pins in
  output logic      [7:0]        host_data_out,       // Host data pins out
  output logic                   host_data_oe_out,    // Host data drive
  output logic                   host_wr_valid_out,   // Write taken pulse
  output logic                   host_wr_cmd_out,     // Write was a command
  output logic      [7:0]        host_wr_data_out,    // Write byte
  output logic                   host_rd_valid_out,   // Read started pulse
  output logic                   host_rd_data_out,    // Read was data read
  input  wire logic [7:0]        status_in,           // Status flag byte
  input  wire logic [7:0]        rd_data_in,          // Data read byte
  input  wire logic [BYTE_W-1:0] bytes_per_line_in,   // Bytes fetched a line
  input  wire logic [LINE_W-1:0] lines_per_frame_in,  // Lines in a frame
  input  wire logic [15:0]       disp_base_in,        // Frame start address
  input  wire logic              cg_mode_in,          // Character access
  input  wire logic              ac_select_in,        // AC period choice
  input  wire logic              sleep_in,            // Sleep requested
  input  wire logic              mem_wr_req_in,       // Memory write request
  input  wire logic [15:0]       mem_wr_addr_in,      // Memory write address
  input  wire logic [7:0]        mem_wr_data_in,      // Memory write byte
  output logic                   mem_wr_done_out,     // Memory write done
  output logic      [15:0]       vram_addr_out,       // Memory address
  input  wire logic [7:0]        vram_data_in,        // Memory data in
  output logic      [7:0]        vram_data_out,       // Memory data out
  output logic                   vram_data_oe_out,    // Memory data drive
  output logic                   vram_write_n_out,    // Memory write strobe
  output logic                   vram_read_n_out,     // Memory read strobe
  output logic                   vram_standby_n_out,  // Memory standby
  output logic                   vram_dir_out,        // High read, low write
  output logic      [3:0]        column_data_out,     // Column nibble
  output logic                   column_shift_clk_out,        // Column clock
  output logic                   column_enable_chain_clk_out, // Chain clock
  output logic                   line_latch_pulse_out,        // Line latch
  output logic                   ac_drive_out,        // AC drive
  output logic                   row_shift_clk_out,   // Row shift clock
  output logic                   row_scan_pulse_out,  // Row scan data
  output logic                   row_drive_on_out     // Row drive enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  lcd_drive_pkg::host_pins_s hp;
  lcd_drive_pkg::host_pins_s hp_prev;
  logic                      style;
  logic                      hw_rst;

  pin_sync #(.W(12), .RST_VAL(lcd_drive_pkg::HOST_PINS_IDLE)) u_host_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     ({cs_n_in, cmd_data_select_in, rd_e_in, wr_rw_in, host_data_in}),
    .sync_out   (hp)
  );

  // Style and reset pins are static or slow, so one filter serves both
  pin_sync #(.W(2), .RST_VAL(2'h0)) u_ctrl_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     ({bus_style_select_in, hardware_reset_in}),
    .sync_out   ({style, hw_rst})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host port decode

  logic read_act;
  logic write_evt;

  always_comb begin
    if (!style) begin
      read_act  = !hp.cs_n && !hp.rd_e;
      write_evt = !hp_prev.cs_n && !hp_prev.wr_rw && hp.wr_rw;
    end else begin
      read_act  = !hp.cs_n && hp.rd_e && hp.wr_rw;
      write_evt = !hp_prev.cs_n && hp_prev.rd_e && !hp_prev.wr_rw && !hp.rd_e;
    end
  end

  // Data is taken from the cycle before the closing edge, when it was settled
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hp_prev           <= lcd_drive_pkg::HOST_PINS_IDLE;
      host_data_out     <= 8'h00;
      host_data_oe_out  <= 1'b0;
      host_wr_valid_out <= 1'b0;
      host_wr_cmd_out   <= 1'b0;
      host_wr_data_out  <= 8'h00;
      host_rd_valid_out <= 1'b0;
      host_rd_data_out  <= 1'b0;
    end else if (hw_rst) begin
      hp_prev           <= lcd_drive_pkg::HOST_PINS_IDLE;
      host_data_oe_out  <= 1'b0;
      host_wr_valid_out <= 1'b0;
      host_rd_valid_out <= 1'b0;
    end else begin
      hp_prev <= hp;
      host_data_oe_out  <= read_act;
      host_data_out     <= hp.cmd_sel ? rd_data_in : status_in;
      host_rd_valid_out <= read_act && !host_data_oe_out;
      host_rd_data_out  <= hp.cmd_sel;
      host_wr_valid_out <= write_evt;
      if (write_evt) begin
        host_wr_cmd_out  <= hp_prev.cmd_sel;
        host_wr_data_out <= hp_prev.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line sequencer and panel timing

  lcd_drive_pkg::line_state_e state;
  logic [1:0]        ph;
  logic              nib;
  logic [7:0]        shift_byte;
  logic [BYTE_W-1:0] byte_cnt;
  logic [LINE_W-1:0] line_cnt;
  logic [15:0]       fetch_addr;
  logic [7:0]        ac_cnt;
  logic              sleep_armed;
  logic              last_line;
  logic              frame_end;

  assign last_line = (line_cnt == lines_per_frame_in - LINE_W'(1));
  assign frame_end = (state == lcd_drive_pkg::ST_LATCH) && (ph == lcd_drive_pkg::PH_FALL)
                     && last_line;

  // Fetch address; the low four bits carry the row counter for characters
  function automatic logic [15:0] fetch_word(input logic [15:0] a, input logic cg,
                                             input logic [3:0] row);
    fetch_word = cg ? {a[15:4], row} : a;
  endfunction

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state                       <= lcd_drive_pkg::ST_SLEEP;
      ph                          <= lcd_drive_pkg::PH_SET;
      nib                         <= 1'b0;
      shift_byte                  <= 8'h00;
      byte_cnt                    <= '0;
      line_cnt                    <= '0;
      fetch_addr                  <= 16'h0000;
      sleep_armed                 <= 1'b0;
      vram_addr_out               <= 16'h0000;
      vram_data_out               <= 8'h00;
      vram_data_oe_out            <= 1'b0;
      vram_write_n_out            <= lcd_drive_pkg::STROBE_RST;
      vram_read_n_out             <= lcd_drive_pkg::STROBE_RST;
      vram_standby_n_out          <= lcd_drive_pkg::STANDBY_RST;
      vram_dir_out                <= 1'b1;
      mem_wr_done_out             <= 1'b0;
      column_data_out             <= 4'h0;
      column_shift_clk_out        <= 1'b0;
      column_enable_chain_clk_out <= 1'b0;
      line_latch_pulse_out        <= lcd_drive_pkg::LATCH_RST;
      row_shift_clk_out           <= lcd_drive_pkg::LATCH_RST;
      row_scan_pulse_out          <= 1'b0;
      row_drive_on_out            <= lcd_drive_pkg::DRIVE_RST;
    end else if (hw_rst) begin
      state                       <= lcd_drive_pkg::ST_SLEEP;
      ph                          <= lcd_drive_pkg::PH_SET;
      sleep_armed                 <= 1'b0;
      vram_data_oe_out            <= 1'b0;
      vram_write_n_out            <= lcd_drive_pkg::STROBE_RST;
      vram_read_n_out             <= lcd_drive_pkg::STROBE_RST;
      vram_standby_n_out          <= lcd_drive_pkg::STANDBY_RST;
      vram_dir_out                <= 1'b1;
      mem_wr_done_out             <= 1'b0;
      column_shift_clk_out        <= 1'b0;
      column_enable_chain_clk_out <= 1'b0;
      line_latch_pulse_out        <= lcd_drive_pkg::LATCH_RST;
      row_shift_clk_out           <= lcd_drive_pkg::LATCH_RST;
      row_scan_pulse_out          <= 1'b0;
      row_drive_on_out            <= lcd_drive_pkg::DRIVE_RST;
    end else begin
      ph              <= ph + 2'h1;
      mem_wr_done_out <= 1'b0;
      case (state)
        lcd_drive_pkg::ST_SLEEP: begin
          ph <= lcd_drive_pkg::PH_SET;
          if (!sleep_in) begin
            row_drive_on_out   <= 1'b1;
            // memory out of standby while active
            vram_standby_n_out <= 1'b0;
            line_cnt           <= '0;
            byte_cnt           <= '0;
            nib                <= 1'b0;
            fetch_addr         <= disp_base_in;
            row_scan_pulse_out <= 1'b0;
            state              <= lcd_drive_pkg::ST_FETCH;
          end
        end
        lcd_drive_pkg::ST_FETCH: begin
          if (ph == lcd_drive_pkg::PH_SET) begin
            vram_addr_out   <= fetch_word(fetch_addr, cg_mode_in, line_cnt[3:0]);
            vram_read_n_out <= 1'b0;
          end else begin
            vram_read_n_out <= 1'b1;
            shift_byte      <= vram_data_in;
            fetch_addr      <= fetch_addr + 16'h0001;
            ph              <= lcd_drive_pkg::PH_SET;
            state           <= lcd_drive_pkg::ST_SHIFT;
          end
        end
        lcd_drive_pkg::ST_SHIFT: begin
          case (ph)
            lcd_drive_pkg::PH_SET:  column_data_out <= nib ? shift_byte[3:0] : shift_byte[7:4];
            lcd_drive_pkg::PH_RISE: column_shift_clk_out <= 1'b1;
            lcd_drive_pkg::PH_HIGH: column_enable_chain_clk_out <= 1'b1;
            default: begin
              column_shift_clk_out        <= 1'b0;
              column_enable_chain_clk_out <= 1'b0;
              nib                         <= !nib;
              if (nib) begin
                if (byte_cnt == bytes_per_line_in - BYTE_W'(1)) begin
                  byte_cnt <= '0;
                  line_latch_pulse_out <= 1'b1;
                  row_shift_clk_out    <= 1'b1;
                  state                <= lcd_drive_pkg::ST_LATCH;
                end else begin
                  byte_cnt <= byte_cnt + BYTE_W'(1);
                  state    <= lcd_drive_pkg::ST_FETCH;
                end
              end
            end
          endcase
        end
        lcd_drive_pkg::ST_LATCH: begin
          // row clock falls a phase early, while scan data still stands
          if (ph == lcd_drive_pkg::PH_HIGH) begin
            row_shift_clk_out <= 1'b0;
          end
          if (ph == lcd_drive_pkg::PH_FALL) begin
            line_latch_pulse_out <= 1'b0;
            if (last_line) begin
              line_cnt   <= '0;
              fetch_addr <= disp_base_in;
            end else begin
              line_cnt <= line_cnt + LINE_W'(1);
            end
            row_scan_pulse_out <= last_line ? (lines_per_frame_in == LINE_W'(1))
                                  : (line_cnt == lines_per_frame_in - LINE_W'(2));
            // sleep after one or two frames
            if (!sleep_in) begin
              sleep_armed <= 1'b0;
            end else if (last_line) begin
              sleep_armed <= 1'b1;
            end
            if (frame_end && sleep_in && sleep_armed) begin
              row_drive_on_out   <= 1'b0;
              vram_standby_n_out <= 1'b1;
              row_scan_pulse_out <= 1'b0;
              sleep_armed        <= 1'b0;
              state              <= lcd_drive_pkg::ST_SLEEP;
            end else if (mem_wr_req_in) begin
              state <= lcd_drive_pkg::ST_WRITE;
            end else begin
              state <= lcd_drive_pkg::ST_FETCH;
            end
          end
        end
        lcd_drive_pkg::ST_WRITE: begin
          case (ph)
            lcd_drive_pkg::PH_SET: begin
              vram_addr_out    <= mem_wr_addr_in;
              vram_data_out    <= mem_wr_data_in;
              vram_dir_out     <= 1'b0;
              vram_data_oe_out <= 1'b1;
            end
            lcd_drive_pkg::PH_RISE: vram_write_n_out <= 1'b0;
            lcd_drive_pkg::PH_HIGH: vram_write_n_out <= 1'b1;
            default: begin
              vram_dir_out     <= 1'b1;
              vram_data_oe_out <= 1'b0;
              mem_wr_done_out  <= 1'b1;
              state            <= lcd_drive_pkg::ST_FETCH;
            end
          endcase
        end
        default: state <= lcd_drive_pkg::ST_SLEEP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AC drive: per frame, or every few lines for panels that need it faster

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ac_drive_out <= 1'b0;
      ac_cnt       <= 8'h00;
    end else if (hw_rst) begin
      ac_drive_out <= 1'b0;
      ac_cnt       <= 8'h00;
    end else if (state == lcd_drive_pkg::ST_LATCH && ph == lcd_drive_pkg::PH_FALL) begin
      if (!ac_select_in) begin
        ac_cnt <= 8'h00;
        if (last_line) begin
          ac_drive_out <= !ac_drive_out;
        end
      end else if (ac_cnt == lcd_drive_pkg::AC_LINES - 8'h01) begin
        ac_cnt       <= 8'h00;
        ac_drive_out <= !ac_drive_out;
      end else begin
        ac_cnt <= ac_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in || hw_rst);

  host_oe_a: assert property (host_data_oe_out && !style |-> $past(!hp.rd_e && !hp.cs_n))
    else $error("host bus driven outside read strobe");
  cs_gate_a: assert property (host_wr_valid_out |-> $past(!hp_prev.cs_n))
    else $error("write taken without chip select");
  wr_edge_a: assert property (host_wr_valid_out && !style |-> $past(hp.wr_rw && !hp_prev.wr_rw))
    else $error("write not on strobe rising edge");
  cmd_sel_a: assert property (host_wr_valid_out |-> host_wr_cmd_out == $past(hp_prev.cmd_sel))
    else $error("command select mismatch");
  vram_dir_a: assert property (vram_data_oe_out |-> !vram_dir_out)
    else $error("memory data driven in read direction");
  row_addr_a: assert property (!vram_read_n_out && cg_mode_in |->
                               vram_addr_out[3:0] == line_cnt[3:0])
    else $error("row bits missing from character address");
  col_stable_a: assert property ($fell(column_shift_clk_out) |->
                                 $stable(column_data_out) && $past($stable(column_data_out)))
    else $error("column data moved at shift edge");
  clk_halt_a: assert property (line_latch_pulse_out |-> !column_shift_clk_out)
    else $error("shift clock ran during latch");
  latch_width_a: assert property ($rose(line_latch_pulse_out) |->
                               line_latch_pulse_out [*4] ##1 !line_latch_pulse_out)
    else $error("line latch width wrong");
  row_scan_a: assert property (row_scan_pulse_out |-> last_line)
    else $error("scan pulse off last line");
  row_clk_a: assert property ($fell(row_shift_clk_out) |-> $stable(row_scan_pulse_out))
    else $error("scan pulse moved at row clock edge");
  drive_off_a: assert property ($fell(row_drive_on_out) |-> $past(frame_end && sleep_in))
    else $error("drive dropped outside frame end");
  standby_a: assert property (!vram_read_n_out || !vram_write_n_out |-> !vram_standby_n_out)
    else $error("memory strobed in standby");

endmodule // lcd_panel_drive

// *** bench/lcd_driver_model.sv ***
// Behavioural column and row driver chips hung on the panel outputs
module lcd_driver_model (
  input  wire logic [3:0] column_data_in,  // Column nibble
  input  wire logic       shift_clk_in,    // Column shift clock
  input  wire logic       chain_clk_in,    // Enable-chain clock
  input  wire logic       latch_in,        // Line latch
  input  wire logic       row_clk_in,      // Row shift clock
  input  wire logic       row_scan_in,     // Row scan data
  input  wire logic       row_on_in,       // Row drive enable
  output int              line_nibs_out,   // Nibbles of last line
  output int              lines_out,       // Lines latched
  output int              scans_out,       // Scan pulses shifted in
  output logic            blank_out        // Rows held at blanking level
);
  timeunit 1ns;
  timeprecision 1ns;
  int         nibs  = 0;
  int         chain = 0;
  logic [3:0] nib_reg;
  initial {line_nibs_out, lines_out, scans_out} = '0;
  // nibble taken at falling shift edge
  always @(negedge shift_clk_in) begin
    nib_reg = column_data_in;
    nibs++;
  end
  // every sixteenth chain pulse would pass the enable on
  always @(negedge chain_clk_in) chain++;
  // falling latch moves the line into the outputs
  always @(negedge latch_in) begin
    line_nibs_out = nibs;
    nibs = 0;
    lines_out++;
  end
  // scan pulse shifted in at falling row clock
  always @(negedge row_clk_in) if (row_scan_in) scans_out++;
  // rows blank whenever the drive enable is low
  assign blank_out = !row_on_in;
endmodule // lcd_driver_model

// *** bench/lcd_panel_drive_tb_top.sv ***
// Self-checking bench for the LCD panel drive block
module lcd_panel_drive_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rst_in = 1, hw_rst = 0, style = 0, sleep = 0, chk_on = 1;
  logic cds = 0, cg = 0, cs_n = 1, rd_e = 1, wr_rw = 1, mem_req = 0;
  logic [7:0] hdata = 0, status = 0, rdata = 0, vdata = 0, mdata = 0, hout, wdat, vout;
  logic [15:0] base = 0, maddr = 0, vaddr;
  logic [3:0] col;
  logic oe, wv, wc, mdone, voe, vw_n, vr_n, vsb_n, vdir, sclk, cclk, lat, ac, rclk, scan, ron;
  logic blank, rdd, rv;
  int fails = 0, n_tests = 0, seed = 8, k, lines, nibs, scans, ac_n = 0, rv_n = 0;
  logic [8:0] exp_q[$];
  lcd_panel_drive u_lcd_panel_drive (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .hardware_reset_in(hw_rst), .bus_style_select_in(style), .cmd_data_select_in(cds),
    .cs_n_in(cs_n), .rd_e_in(rd_e), .wr_rw_in(wr_rw), .host_data_in(hdata),
    .host_data_out(hout), .host_data_oe_out(oe), .host_wr_valid_out(wv),
    .host_wr_cmd_out(wc), .host_wr_data_out(wdat), .host_rd_valid_out(rv),
    .host_rd_data_out(rdd), .status_in(status), .rd_data_in(rdata), .bytes_per_line_in(8'h02),
    .lines_per_frame_in(8'h03), .disp_base_in(base), .cg_mode_in(cg), .ac_select_in(1'b1),
    .sleep_in(sleep), .mem_wr_req_in(mem_req), .mem_wr_addr_in(maddr),
    .mem_wr_data_in(mdata), .mem_wr_done_out(mdone), .vram_addr_out(vaddr),
    .vram_data_in(vdata), .vram_data_out(vout), .vram_data_oe_out(voe),
    .vram_write_n_out(vw_n), .vram_read_n_out(vr_n), .vram_standby_n_out(vsb_n),
    .vram_dir_out(vdir), .column_data_out(col), .column_shift_clk_out(sclk),
    .column_enable_chain_clk_out(cclk), .line_latch_pulse_out(lat), .ac_drive_out(ac),
    .row_shift_clk_out(rclk), .row_scan_pulse_out(scan), .row_drive_on_out(ron));
  lcd_driver_model u_lcd_driver_model (.column_data_in(col), .shift_clk_in(sclk),
    .chain_clk_in(cclk), .latch_in(lat), .row_clk_in(rclk), .row_scan_in(scan),
    .row_on_in(ron), .line_nibs_out(nibs), .lines_out(lines), .scans_out(scans),
    .blank_out(blank));
  always #50 clk_sys_in = ~clk_sys_in;
  // Memory data pins wander every cycle
  always @(negedge clk_sys_in) vdata <= 8'($random(seed));
  always @(ac) ac_n++;
  always @(posedge clk_sys_in) if (rv === 1'b1) rv_n++;
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // one host write; strobe levels held 400 ns each
  task automatic host_wr(logic sel, logic cmd, logic [7:0] d);
    cs_n = sel;
    cds = cmd;
    hdata = d;
    wr_rw = 0;
    if (!sel) exp_q.push_back({cmd, d});
    cyc(4);
    if (style) rd_e = 1; else wr_rw = 1;
    cyc(4);
    if (style) rd_e = 0;
    cyc(4);
    cs_n = 1;
    wr_rw = 1;
    cyc(4);
  endtask
  // read drives the host bus only while active
  task automatic host_rd(logic cmd);
    status = 8'($random(seed));
    rdata = 8'($random(seed));
    cs_n = 0;
    cds = cmd;
    rd_e = style;
    cyc(7);
    check("read oe", 16'(oe), 16'h0001);
    check("read byte", 16'(hout), 16'(cmd ? rdata : status));
    check("read kind", 16'(rdd), 16'(cmd));
    rd_e = !style;
    cs_n = 1;
    cyc(7);
    check("idle oe", 16'(oe), 16'h0000);
  endtask
  // taken writes pair with the expected queue
  always @(posedge clk_sys_in) if (wv === 1'b1) begin
    check("write taken", 16'(exp_q.size() > 0), 16'h0001);
    if (exp_q.size() > 0) check("write", 16'({wc, wdat}), 16'(exp_q.pop_front()));
  end
  // memory bus driven only for writes, with the asked address
  always @(posedge clk_sys_in) begin
    if (voe === 1'b1) check("mem dir", 16'(vdir), 16'h0000);
    if (vw_n === 1'b0) check("mem addr", vaddr, maddr);
    if (vw_n === 1'b0) check("mem data", 16'(vout), 16'(mdata));
  end
  // two nibbles per byte reach the drivers each line
  always @(negedge lat) if (chk_on) #1 check("nibbles", 16'(nibs), 16'h0004);
  initial begin
    base = 16'($random(seed));
    cyc(12);
    rst_in = 0;
    cyc(8);
    check("drive on", 16'(ron), 16'h0001);
    for (k = 0; k < 4; k++) host_wr(k[1], k[0], 8'($random(seed)));
    host_rd(0);
    host_rd(1);
    maddr = 16'($random(seed));
    mdata = 8'($random(seed));
    mem_req = 1;
    for (k = 0; k < 400 && mdone !== 1'b1; k++) cyc(1);
    mem_req = 0;
    check("mem done", 16'(k < 400), 16'h0001);
    // sleep drops the drive one to two frames later
    @(negedge lat);
    sleep = 1;
    k = lines;
    repeat (2000) if (ron === 1'b1) cyc(1);
    check("sleep lines", 16'((lines - k) inside {[2:7]}), 16'h0001);
    check("standby", 16'(vsb_n), 16'h0001);
    sleep = 0;
    cyc(20);
    check("wake", 16'(ron), 16'h0001);
    check("scans", 16'((lines / 3 - scans) inside {[-1:1]}), 16'h0001);
    check("ac", 16'((lines / 16 - ac_n) inside {[-1:1]}), 16'h0001);
    // bus style changes only under hardware reset
    chk_on = 0;
    hw_rst = 1;
    cyc(8);
    check("reset drive", 16'(ron), 16'h0000);
    style = 1;
    cg = 1;
    rd_e = 0;
    cyc(4);
    hw_rst = 0;
    cyc(10);
    // Partial line cut by the reset is skipped before checking nibbles again
    @(negedge lat);
    cyc(1);
    chk_on = 1;
    for (k = 0; k < 4; k++) host_wr(k[1], k[0], 8'($random(seed)));
    host_rd(0);
    host_rd(1);
    check("queue", 16'(exp_q.size()), 16'h0000);
    check("reads", 16'(rv_n), 16'h0004);
    wrap_up();
  end
  initial begin
    #3000000;
    fails++;
    wrap_up();
  end
endmodule // lcd_panel_drive_tb_top
